// ==== hdl/ied_irq_entry.sv ====
// Purpose: Interrupt entry, dispatch table fetch and return sequencing
// Assumes: Memory drives read data while the registered read request stands, never waits
// Notes: Register reads return one cycle after the read strobe
`timescale 1ns/1ns
module ied_irq_entry import ied_pkg::*; (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic nmi_pin_n,
    input wire logic [TRAP_COUNT-1:0] trap_req,
    input wire logic [LINE_COUNT-1:0] irq_line,
    input wire logic [LINE_COUNT-1:0] periph_en,
    input wire logic return_from_exception_req,
    output ied_mem_req_t mem_req,
    input wire logic [15:0] mem_rdata,
    output logic [20:0] program_counter,
    output logic [15:0] processor_status_word,
    output logic exc_ack,
    output logic [4:0] exc_vec,
    output logic busy,
    output logic irq_out
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    ied_state_t state_r, state_nxt;
    logic [20:0] pc_r, pc_nxt;
    logic [15:0] psw_r, psw_nxt;
    logic [15:0] isp_r, isp_nxt;
    logic [15:1] base_r, base_nxt;
    logic [15:0] mask_r, mask_nxt;
    logic [4:0] vec_r, vec_nxt;
    logic [4:0] pick_vec_r, pick_vec_nxt;
    ied_mem_req_t mem_r, mem_nxt;
    logic ack_r, ack_nxt;
    logic [4:0] ack_vec_r, ack_vec_nxt;
    logic nmi_pend_r, nmi_pend_nxt;
    logic [1:0] nmi_ctl_r, nmi_ctl_nxt;
    logic [EVT_BITS-1:0] evt_r, evt_nxt;
    logic [EVT_BITS-1:0] evt_mask_r, evt_mask_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic irq_r, irq_nxt;
    logic busy_r, busy_nxt;

    logic nmi_fall;
    logic [LINE_COUNT-1:0] line_ok;
    logic pick_valid;
    logic [4:0] pick_vec;
    logic idle;
    logic take;
    logic take_nmi;
    logic ret_start;
    logic entry_done;
    logic ret_done;
    logic wr_ok;

    // ------------------------------------------------------------
    // Request qualification
    // ------------------------------------------------------------
    ied_nmi_edge u_nmi (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .pin_n(nmi_pin_n),
        .fall(nmi_fall)
    );

    generate
        for (genvar g = 0; g < LINE_COUNT; g++) begin : g_line
            // A line is taken only with all four enables set
            assign line_ok[g] = irq_line[g] & periph_en[g] & mask_r[g] & ~LINE_RESERVED[g]
                              & psw_r[PSW_GLOBAL_EN] & psw_r[PSW_LOCAL_EN]; // RL17 RL18
        end
    endgenerate

    ied_vec_pick #(.LINES(LINE_COUNT)) u_pick (
        .nmi(nmi_pend_r),
        .trap(trap_req),
        .line(line_ok),
        .valid(pick_valid),
        .vec(pick_vec)
    ); // RL13

    assign idle = (state_r == ST_IDLE);
    // Return is an instruction already executing, so it goes before a new entry
    assign ret_start = idle & return_from_exception_req;
    assign take = idle & ~return_from_exception_req & pick_valid;
    assign take_nmi = take & (pick_vec == VEC_NMI);
    assign entry_done = (state_r == ST_LOAD);
    assign ret_done = (state_r == ST_POP_PSW);
    // Core state is not writable by software mid-sequence
    assign wr_ok = reg_wr & idle;

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        pc_nxt = pc_r;
        psw_nxt = psw_r;
        isp_nxt = isp_r;
        vec_nxt = vec_r;
        pick_vec_nxt = pick_vec_r;
        mem_nxt = '0;
        ack_nxt = 1'b0;
        ack_vec_nxt = ack_vec_r;
        if (wr_ok && reg_addr == REG_PROG_COUNTER) begin
            pc_nxt = {reg_wdata[20:1], 1'b0};
        end
        if (wr_ok && reg_addr == REG_STATUS_WORD) begin
            psw_nxt = reg_wdata[15:0];
        end
        if (wr_ok && reg_addr == REG_STACK_PTR) begin
            isp_nxt = reg_wdata[15:0]; // RL19
        end
        unique case (state_r)
            ST_IDLE: begin
                if (ret_start) begin
                    mem_nxt.rd = 1'b1;
                    mem_nxt.addr = {5'h00, isp_r};
                    state_nxt = ST_POP_PC;
                end else if (take) begin
                    isp_nxt = isp_r - STACK_STEP; // RL1
                    pick_vec_nxt = pick_vec;
                    ack_nxt = 1'b1;
                    ack_vec_nxt = pick_vec;
                    state_nxt = ST_PUSH_PC;
                end
            end
            ST_PUSH_PC: begin
                mem_nxt.wr = 1'b1;
                mem_nxt.addr = {5'h00, isp_r};
                mem_nxt.wdata = pc_r[16:1]; // RL2
                state_nxt = ST_PUSH_PSW;
            end
            ST_PUSH_PSW: begin
                mem_nxt.wr = 1'b1;
                mem_nxt.addr = {5'h00, isp_r + PSW_SLOT};
                mem_nxt.wdata = psw_r; // RL2
                psw_nxt[PSW_GLOBAL_EN] = 1'b0; // RL3
                psw_nxt[PSW_TRACE_PEND] = 1'b0; // RL3
                psw_nxt[PSW_TRACE] = 1'b0; // RL3
                state_nxt = ST_FETCH;
            end
            ST_FETCH: begin
                vec_nxt = pick_vec_r; // RL4
                mem_nxt.rd = 1'b1;
                mem_nxt.addr = {5'h00, base_r, 1'b0} + {15'h0000, pick_vec_r, 1'b0}; // RL5 RL10
                state_nxt = ST_LOAD;
            end
            ST_LOAD: begin
                pc_nxt = {4'h0, mem_rdata, 1'b0}; // RL5 RL7 RL8
                state_nxt = ST_IDLE;
            end
            ST_POP_PC: begin
                pc_nxt = {4'h0, mem_rdata, 1'b0}; // RL6
                mem_nxt.rd = 1'b1;
                mem_nxt.addr = {5'h00, isp_r + PSW_SLOT};
                state_nxt = ST_POP_PSW;
            end
            ST_POP_PSW: begin
                psw_nxt = mem_rdata; // RL6
                isp_nxt = isp_r + STACK_STEP; // RL6
                state_nxt = ST_IDLE;
            end
        endcase
        // Registered copy of the next state keeps the output glitch free
        busy_nxt = (state_nxt != ST_IDLE);
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IDLE;
            pc_r <= PC_RESET;
            psw_r <= PSW_RESET;
            isp_r <= ISP_RESET;
            vec_r <= 5'h00;
            pick_vec_r <= 5'h00;
            mem_r <= '0;
            ack_r <= 1'b0;
            ack_vec_r <= 5'h00;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
            psw_r <= psw_nxt;
            isp_r <= isp_nxt;
            vec_r <= vec_nxt;
            pick_vec_r <= pick_vec_nxt;
            mem_r <= mem_nxt;
            ack_r <= ack_nxt;
            ack_vec_r <= ack_vec_nxt;
            busy_r <= busy_nxt;
        end
    end

    // ------------------------------------------------------------
    // Software registers, events and read port
    // ------------------------------------------------------------
    always_comb begin
        base_nxt = base_r;
        mask_nxt = mask_r;
        nmi_ctl_nxt = nmi_ctl_r;
        evt_mask_nxt = evt_mask_r;
        evt_nxt = evt_r;
        rdata_nxt = 32'h00000000;
        nmi_pend_nxt = nmi_pend_r & ~take_nmi;
        if (reg_wr) begin
            unique case (reg_addr)
                REG_DISPATCH_BASE: base_nxt = reg_wdata[15:1]; // RL10 RL11
                REG_MASK_WORD: mask_nxt = reg_wdata[15:0];
                REG_EVT_MASK: evt_mask_nxt = reg_wdata[EVT_BITS-1:0];
                REG_EVT_STATUS: evt_nxt = evt_r & ~reg_wdata[EVT_BITS-1:0];
                REG_NMI_CTRL: begin
                    nmi_ctl_nxt[NMI_EN] = reg_wdata[NMI_EN];
                    // Lock can only be set; reset alone clears it
                    nmi_ctl_nxt[NMI_LOCK] = nmi_ctl_r[NMI_LOCK] | reg_wdata[NMI_LOCK];
                end
                default: ;
            endcase
        end
        // Single-shot enable drops on each taken edge unless locked
        if (take_nmi && !nmi_ctl_r[NMI_LOCK]) begin
            nmi_ctl_nxt[NMI_EN] = 1'b0;
        end
        // Setting events win over a same-cycle clear
        if (nmi_fall && (nmi_ctl_r[NMI_EN] || nmi_ctl_r[NMI_LOCK])) begin
            nmi_pend_nxt = 1'b1; // RL16
            evt_nxt[EVT_NMI_EDGE] = 1'b1;
        end
        if (entry_done) begin
            evt_nxt[EVT_ENTRY] = 1'b1;
        end
        if (ret_done) begin
            evt_nxt[EVT_RETURN] = 1'b1;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                REG_DISPATCH_BASE: rdata_nxt = {11'h000, 5'h00, base_r, 1'b0}; // RL10
                REG_STACK_PTR: rdata_nxt = {16'h0000, isp_r};
                REG_STATUS_WORD: rdata_nxt = {16'h0000, psw_r};
                REG_PROG_COUNTER: rdata_nxt = {11'h000, pc_r};
                REG_MASK_WORD: rdata_nxt = {16'h0000, mask_r};
                REG_VECTOR: rdata_nxt = {27'h0000000, vec_r}; // RL4
                REG_NMI_CTRL: rdata_nxt = {30'h00000000, nmi_ctl_r};
                REG_EVT_STATUS: rdata_nxt = {29'h00000000, evt_r};
                REG_EVT_MASK: rdata_nxt = {29'h00000000, evt_mask_r};
                default: rdata_nxt = 32'h00000000;
            endcase
        end
        irq_nxt = |(evt_nxt & evt_mask_nxt);
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            base_r <= 15'h0000;
            mask_r <= 16'h0000;
            nmi_ctl_r <= 2'h0;
            nmi_pend_r <= 1'b0;
            evt_r <= '0;
            evt_mask_r <= '0;
            rdata_r <= 32'h00000000;
            irq_r <= 1'b0;
        end else begin
            base_r <= base_nxt;
            mask_r <= mask_nxt;
            nmi_ctl_r <= nmi_ctl_nxt;
            nmi_pend_r <= nmi_pend_nxt;
            evt_r <= evt_nxt;
            evt_mask_r <= evt_mask_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = rdata_r;
    assign mem_req = mem_r;
    assign program_counter = pc_r;
    assign processor_status_word = psw_r;
    assign exc_ack = ack_r;
    assign exc_vec = ack_vec_r;
    assign busy = busy_r;
    assign irq_out = irq_r;
endmodule : ied_irq_entry

// ==== hdl/ied_nmi_edge.sv ====
// Purpose: Synchronise the non-maskable pin and flag its falling edge
// Assumes: Pin is asynchronous to sys_clk
// Notes: Edge pulse lags the pin by two clocks
`timescale 1ns/1ns
module ied_nmi_edge import ied_pkg::*; (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic pin_n,
    output logic fall
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // ------------------------------------------------------------
    // Two-stage synchroniser, then edge detect on the second stage
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            last_r <= 1'b1;
        end else begin
            meta_r <= pin_n;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign fall = last_r & ~sync_r; // RL16
endmodule : ied_nmi_edge

// ==== hdl/ied_pkg.sv ====
// Purpose: Shared constants and types for the interrupt entry and dispatch unit
// Assumes: One 100 MHz core clock, asynchronous active-low reset
// Notes: How it works list below; register offsets are word indexes on the plain register port
//
// How it works
// RL1: Stack pointer drops four before any store.
// RL2: Program counter, then status word, go onto stack.
// RL3: Entry clears global enable, trace pending, trace.
// RL4: Vector number is latched into vector register.
// RL5: Entry address is base plus twice vector.
// RL6: Return pops counter and status, pointer rises four.
// RL7: Table entry holds address bits one to sixteen.
// RL8: Entry rebuilt with zero below and zeros above.
// RL9: Software keeps routines inside program memory range.
// RL10: Base is 21 bits, top five and bit zero zero.
// RL11: Software loads base before enabling any interrupt.
// RL12: Table is 32 words at legal even start.
// RL13: Every source maps to one vector zero to 31.
// RL14: Vector 1 non-maskable, 5 to 10 traps.
// RL15: Vectors 16 to 31 carry maskable peripheral lines.
// RL16: Non-maskable falling edge wins over everything else. The code lets a return request in the same idle cycle go first.
// RL17: Peripheral requests are all maskable interrupts.
// RL18: Maskable needs peripheral, mask, global and local enables.
// RL19: Software sets stack pointer first; stack grows downward.
package ied_pkg;

    // ------------------------------------------------------------
    // Register indexes
    // ------------------------------------------------------------
    localparam logic [3:0] REG_DISPATCH_BASE = 4'h0;
    localparam logic [3:0] REG_STACK_PTR = 4'h1;
    localparam logic [3:0] REG_STATUS_WORD = 4'h2;
    localparam logic [3:0] REG_PROG_COUNTER = 4'h3;
    localparam logic [3:0] REG_MASK_WORD = 4'h4;
    localparam logic [3:0] REG_VECTOR = 4'h5;
    localparam logic [3:0] REG_NMI_CTRL = 4'h6;
    localparam logic [3:0] REG_EVT_STATUS = 4'h7;
    localparam logic [3:0] REG_EVT_MASK = 4'h8;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int PSW_TRACE = 1;
    localparam int PSW_TRACE_PEND = 2;
    localparam int PSW_LOCAL_EN = 9;
    localparam int PSW_GLOBAL_EN = 11;
    localparam int NMI_EN = 0;
    localparam int NMI_LOCK = 1;
    localparam int EVT_ENTRY = 0;
    localparam int EVT_RETURN = 1;
    localparam int EVT_NMI_EDGE = 2;
    localparam int EVT_BITS = 3;
    localparam logic [15:0] PSW_RESET = 16'h0000;
    localparam logic [15:0] ISP_RESET = 16'h0000;
    localparam logic [20:0] PC_RESET = 21'h000000;
    localparam logic [15:0] STACK_STEP = 16'h0004;
    localparam logic [15:0] PSW_SLOT = 16'h0002;

    // ------------------------------------------------------------
    // Vector map
    // ------------------------------------------------------------
    localparam int TRAP_COUNT = 6;
    localparam int LINE_COUNT = 16;
    localparam logic [4:0] VEC_NMI = 5'h01;
    localparam logic [4:0] VEC_TRAP_BASE = 5'h05;
    localparam logic [4:0] VEC_LINE_BASE = 5'h10;
    // Lines 16, 19, 23 and 31 have no source
    localparam logic [15:0] LINE_RESERVED = 16'h8089;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [20:0] addr;
        logic [15:0] wdata;
    } ied_mem_req_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PUSH_PC,
        ST_PUSH_PSW,
        ST_FETCH,
        ST_LOAD,
        ST_POP_PC,
        ST_POP_PSW
    } ied_state_t;

endpackage : ied_pkg

// ==== hdl/ied_vec_pick.sv ====
// Purpose: Pick the winning request and give its vector number
// Assumes: Inputs already gated by their enables
// Notes: Combinational; higher line index wins among maskable lines
`timescale 1ns/1ns
module ied_vec_pick import ied_pkg::*; #(
    parameter int LINES = LINE_COUNT
) (
    input wire logic nmi,
    input wire logic [TRAP_COUNT-1:0] trap,
    input wire logic [LINES-1:0] line,
    output logic valid,
    output logic [4:0] vec
);
    always_comb begin
        valid = 1'b0;
        vec = 5'h00;
        for (int i = 0; i < LINES; i++) begin
            if (line[i]) begin
                valid = 1'b1;
                vec = VEC_LINE_BASE + 5'(i); // RL15
            end
        end
        for (int j = TRAP_COUNT - 1; j >= 0; j--) begin
            if (trap[j]) begin
                valid = 1'b1;
                vec = VEC_TRAP_BASE + 5'(j); // RL14
            end
        end
        if (nmi) begin
            valid = 1'b1;
            vec = VEC_NMI; // RL16
        end
    end
endmodule : ied_vec_pick

// ==== sim/ied_chk_sva.sv ====
// Purpose: Port checker for the interrupt entry unit
// Assumes: Memory answers a read within the request's cycle
// Notes: Bound to every ied_irq_entry instance
`timescale 1ns/1ns
module ied_chk import ied_pkg::*; (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic return_from_exception_req,
    input wire ied_mem_req_t mem_req,
    input wire logic [15:0] mem_rdata,
    input wire logic [20:0] program_counter,
    input wire logic [15:0] processor_status_word,
    input wire logic exc_ack,
    input wire logic [4:0] exc_vec,
    input wire logic busy
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    // ------------------------------------------------------------
    // Entry and return sequences
    // ------------------------------------------------------------
    property p_entry_len;
        exc_ack |-> busy [*4] ##1 !busy;
    endproperty
    a_entry_len: assert property (p_entry_len) else $error("entry length wrong");
    property p_push_pc;
        exc_ack |=> mem_req.wr && mem_req.wdata == program_counter[16:1];
    endproperty
    a_push_pc: assert property (p_push_pc) else $error("counter push wrong");
    property p_push_psw;
        exc_ack ##1 mem_req.wr |=> mem_req.wr && mem_req.addr == $past(mem_req.addr) + 21'h000002
            && mem_req.wdata == $past(processor_status_word);
    endproperty
    a_push_psw: assert property (p_push_psw) else $error("status push wrong");
    property p_flags;
        exc_ack ##2 mem_req.wr |-> (processor_status_word & 16'h0806) == 16'h0000;
    endproperty
    a_flags: assert property (p_flags) else $error("status flags not cleared");
    property p_fetch;
        exc_ack |-> ##3 (mem_req.rd && !mem_req.wr && !mem_req.addr[0]);
    endproperty
    a_fetch: assert property (p_fetch) else $error("table fetch missing");
    property p_pc_load;
        exc_ack |-> ##4 program_counter == {4'h0, $past(mem_rdata), 1'b0};
    endproperty
    a_pc_load: assert property (p_pc_load) else $error("routine address wrong");
    property p_vec_legal;
        exc_ack |-> exc_vec == VEC_NMI || (exc_vec >= 5'h05 && exc_vec <= 5'h0a)
            || (exc_vec[4] && !LINE_RESERVED[exc_vec[3:0]]);
    endproperty
    a_vec_legal: assert property (p_vec_legal) else $error("vector not mapped");
    property p_ret_pop;
        return_from_exception_req && !busy |=> mem_req.rd ##1 (mem_req.rd && mem_req.addr == $past(mem_req.addr) + 21'h000002);
    endproperty
    a_ret_pop: assert property (p_ret_pop) else $error("return pops wrong");
    property p_ret_end;
        return_from_exception_req && !busy |-> ##[2:4] !busy;
    endproperty
    a_ret_end: assert property (p_ret_end) else $error("return too long");
    cover property (exc_ack && exc_vec == VEC_NMI);
    cover property (exc_ack && exc_vec[4]);
    cover property (return_from_exception_req && !busy);
endmodule : ied_chk
bind ied_irq_entry ied_chk chk_u (.sys_clk, .arst_n, .return_from_exception_req, .mem_req, .mem_rdata, .program_counter,
    .processor_status_word, .exc_ack, .exc_vec, .busy);

// ==== sim/ied_irq_entry_tb_top.sv ====
// Purpose: Self-checking bench for the interrupt entry unit
// Assumes: Memory model answers within the request's cycle
// Notes: Traps, lines, non-maskable pin, return and event interrupt
`timescale 1ns/1ns
module ied_irq_entry_tb_top import ied_pkg::*;;
    logic sys_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, nmi_pin_n = 1'b1, return_from_exception_req = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    logic [5:0] trap_req = 6'h00;
    logic [15:0] irq_line = 16'h0000, periph_en = 16'hffff, mem_rdata, psw;
    ied_mem_req_t mem_req;
    logic [20:0] pc;
    logic exc_ack, busy, irq_out;
    logic [4:0] exc_vec;
    int mismatches = 0, compares = 0;
    always #5 sys_clk = ~sys_clk;
    ied_irq_entry dut_u (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .nmi_pin_n,
        .trap_req, .irq_line, .periph_en, .return_from_exception_req, .mem_req, .mem_rdata, .program_counter(pc),
        .processor_status_word(psw), .exc_ack, .exc_vec, .busy, .irq_out);
    ied_mem_model mem_u (.sys_clk, .mem_req, .mem_rdata);
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // Waits for the acceptance, drops the request, checks the loaded routine
    task automatic take(input logic [4:0] v);
        int n;
        n = 0;
        while (exc_ack !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        chk("vec", exc_vec, v);
        @(posedge sys_clk);
        if (v[4]) begin
            irq_line[v[3:0]] <= 1'b0;
        end else if (v != VEC_NMI) begin
            trap_req[3'(v - VEC_TRAP_BASE)] <= 1'b0;
        end
        cyc(3);
        chk("busy", busy, 1'b0);
        chk("pc", pc, {4'h0, 16'h0100 + v, 1'b0});
    endtask : take
    // A stack pointer of all ones skips the pointer read
    task automatic ret(input logic [20:0] p, input logic [15:0] s, input logic [15:0] sp);
        int n;
        n = 0;
        @(posedge sys_clk);
        return_from_exception_req <= 1'b1;
        @(posedge sys_clk);
        return_from_exception_req <= 1'b0;
        cyc(1);
        while (busy !== 1'b0 && n < 10) begin
            cyc(1);
            n++;
        end
        chk("rdone", busy, 1'b0);
        cyc(1);
        chk("rpc", pc, p);
        chk("rpsw", psw, s);
        if (sp != 16'hffff) begin
            rd(REG_STACK_PTR);
            chk("isp", d, sp);
        end
    endtask : ret
    task automatic quiet(input logic [4:0] v);
        cyc(12);
        chk("quiet", exc_vec, v);
        chk("idle", busy, 1'b0);
    endtask : quiet
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        for (int a = 1; a < 4; a++) begin
            rd(4'(a));
            chk("reset", d, 32'h0);
        end
        rd(4'h9);
        chk("unmapped", d, 32'h0);
        wr(REG_DISPATCH_BASE, 32'hffffffff);
        rd(REG_DISPATCH_BASE);
        chk("base", d, 32'h0000fffe);
        wr(REG_VECTOR, 32'h1f);
        rd(REG_VECTOR);
        chk("vreg", d, 32'h0);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_traps();
        for (int j = 0; j < TRAP_COUNT; j++) begin
            @(posedge sys_clk);
            trap_req[j] <= 1'b1;
            take(5'(VEC_TRAP_BASE + j));
            chk("psw", psw, 16'h0200);
            chk("stkpc", mem_u.mem[32'h07fc], 16'h091a);
            chk("stkpsw", mem_u.mem[32'h07fe], 16'h0a06);
            rd(REG_VECTOR);
            chk("ivec", d, VEC_TRAP_BASE + j);
            ret(21'h001234, 16'h0a06, 16'h0800);
        end
        $display("t_traps done");
    endtask : t_traps
    // Pin falls during a trap entry; it must beat the waiting trap
    task automatic t_nmi();
        wr(REG_NMI_CTRL, 32'h1);
        @(posedge sys_clk);
        trap_req <= 6'h03;
        nmi_pin_n <= 1'b0;
        take(5'h05);
        take(VEC_NMI);
        take(5'h06);
        ret(21'h000202, 16'h0200, 16'h07f8);
        ret(21'h00020a, 16'h0200, 16'h07fc);
        ret(21'h001234, 16'h0a06, 16'h0800);
        @(posedge sys_clk);
        nmi_pin_n <= 1'b1;
        cyc(5);
        @(posedge sys_clk);
        nmi_pin_n <= 1'b0;
        quiet(5'h06);
        $display("t_nmi done");
    endtask : t_nmi
    task automatic t_lines();
        for (int i = 0; i < LINE_COUNT; i++) begin
            @(posedge sys_clk);
            irq_line[i] <= 1'b1;
            if (LINE_RESERVED[i]) begin
                quiet(i == 0 ? 5'h06 : 5'(VEC_LINE_BASE + i - 1));
                @(posedge sys_clk);
                irq_line[i] <= 1'b0;
            end else begin
                take(5'(VEC_LINE_BASE + i));
                ret(21'h001234, 16'h0a06, 16'h0800);
            end
        end
        @(posedge sys_clk);
        irq_line <= 16'h4002;
        take(5'h1e);
        ret(21'h001234, 16'h0a06, 16'hffff);
        take(5'h11);
        ret(21'h001234, 16'h0a06, 16'h0800);
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk);
            periph_en[14] <= (k != 0);
            wr(REG_MASK_WORD, k == 1 ? 32'hbfff : 32'hffff);
            wr(REG_STATUS_WORD, k == 2 ? 32'h0806 : 32'h0a06);
            @(posedge sys_clk);
            irq_line[14] <= 1'b1;
            quiet(5'h11);
            @(posedge sys_clk);
            irq_line[14] <= 1'b0;
        end
        wr(REG_STATUS_WORD, 32'h0a06);
        $display("t_lines done");
    endtask : t_lines
    task automatic t_irq();
        rd(REG_EVT_STATUS);
        chk("evts", d, 32'h7);
        wr(REG_EVT_MASK, 32'h0);
        cyc(1);
        chk("masked", irq_out, 1'b0);
        wr(REG_EVT_MASK, 32'h2);
        cyc(1);
        chk("irq", irq_out, 1'b1);
        wr(REG_EVT_STATUS, 32'h7);
        cyc(1);
        chk("clr", irq_out, 1'b0);
        rd(REG_EVT_STATUS);
        chk("evts0", d, 32'h0);
        $display("t_irq done");
    endtask : t_irq
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_regs();
        wr(REG_DISPATCH_BASE, 32'h1000);
        wr(REG_STACK_PTR, 32'h0800);
        wr(REG_PROG_COUNTER, 32'h1234);
        wr(REG_STATUS_WORD, 32'h0a06);
        wr(REG_MASK_WORD, 32'hffff);
        wr(REG_EVT_MASK, 32'h7);
        for (int v = 0; v < 32; v++) begin
            mem_u.mem[32'h1000 + 2 * v] = 16'h0100 + 16'(v);
        end
        t_traps();
        t_nmi();
        t_lines();
        t_irq();
        give_verdict();
    end
    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end
endmodule : ied_irq_entry_tb_top

// ==== sim/ied_mem_model.sv ====
// Purpose: Program and stack memory seen by the entry unit
// Assumes: Reads answer within the cycle in which the request stands
// Notes: Outside an answer the data lines show the inverse of the last value
`timescale 1ns/1ns
module ied_mem_model import ied_pkg::*; (
    input wire logic sys_clk,
    input wire ied_mem_req_t mem_req,
    output logic [15:0] mem_rdata
);
    logic [15:0] mem [int];
    initial mem_rdata = 16'h0000;
    // Falling edge answers, so data is settled at the rising edge that samples it
    // Stale data flips each cycle, so a sample one cycle late cannot look right
    always @(negedge sys_clk) begin
        if (mem_req.wr) begin
            mem[int'(mem_req.addr)] = mem_req.wdata;
        end
        if (mem_req.rd && mem.exists(int'(mem_req.addr))) begin
            mem_rdata <= mem[int'(mem_req.addr)];
        end else if (mem_req.rd) begin
            mem_rdata <= 16'h0000;
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule : ied_mem_model
